// >>> verilog/multi_cpu_status_flags_map.vh
/*
 * Address map, field positions, reset values and shared widths of the
 * multi-CPU status flag bank.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
// Overview of operation
// - fuse fault flag rises when any output module reports a blown fuse
// - fuse fault flag stays set until power-on reset, even when fuses recover
// - on a check request the four clock words are validated; flag set or cleared
// - each of four peer slots has a ready flag, high while it can cooperate
// - each slot has an in-reset flag, high while held, low after release
// - halt fault flag does not rise while a peer runs, continuation errors included
// - halt fault flag rises while the peer is stopped by a stop-class error
`ifndef MULTI_CPU_STATUS_FLAGS_MAP_VH
`define MULTI_CPU_STATUS_FLAGS_MAP_VH

// register byte offsets
`define FLAGS_OFS 8'h00
`define CTRL_OFS 8'h04
`define CLK_W0_OFS 8'h08
`define CLK_W1_OFS 8'h0C
`define CLK_W2_OFS 8'h10
`define CLK_W3_OFS 8'h14
`define IRQ_STAT_OFS 8'h18
`define IRQ_MASK_OFS 8'h1C

// flag layout, shared by flags, irq status and irq mask
`define FUSE_BIT 0
`define CLKERR_BIT 1
`define READY_LSB 4
`define INRST_LSB 8
`define HALT_LSB 12
`define FLAG_W 16

// control register fields
`define CTRL_CHECK_BIT 0

// sizes
`define PEERS 4
`define FUSE_MODULES 8
`define CLK_WORD_W 16

// reset values
`define FLAGS_RST 16'h0000
`define CLK_WORD_RST 16'h0000
`define IRQ_MASK_RST 16'h0000

`endif

// >>> verilog/clock_value_checker.v
/*
 * Validates the four stored clock words as packed BCD date and time.
 * Assumes the words are stable while check_i is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "multi_cpu_status_flags_map.vh"
module clock_value_checker (
   input wire clk_i,
   input wire rst_i,
   input wire check_i,
   input wire [`CLK_WORD_W-1:0] word0_i,
   input wire [`CLK_WORD_W-1:0] word1_i,
   input wire [`CLK_WORD_W-1:0] word2_i,
   input wire [`CLK_WORD_W-1:0] word3_i,
   output reg error_o,
   output reg done_o
);
   // -----------------------------------------------
   // bcd field check
   // -----------------------------------------------
   // true when both digits are decimal and the value lies in [lo, hi]
   function bcd_ok;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
      end
   endfunction

   wire valid;
   // word0 year, word1 month/day, word2 hour/minute, word3 second/weekday
   assign valid = bcd_ok(word0_i[15:8], 8'h00, 8'h99) && bcd_ok(word0_i[7:0], 8'h00, 8'h99)
      && bcd_ok(word1_i[15:8], 8'h01, 8'h12) && bcd_ok(word1_i[7:0], 8'h01, 8'h31)
      && bcd_ok(word2_i[15:8], 8'h00, 8'h23) && bcd_ok(word2_i[7:0], 8'h00, 8'h59)
      && bcd_ok(word3_i[15:8], 8'h00, 8'h59) && bcd_ok(word3_i[7:0], 8'h00, 8'h06);

   // result is only meaningful together with done_o
   always @(posedge clk_i) begin
      if (rst_i) begin
         error_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= check_i;
         if (check_i) begin
            error_o <= ~valid;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/peer_slot_flags.v
/*
 * Status flags of one peer CPU slot on the high-speed bus.
 * Assumes its inputs are synchronous levels from the peer monitor.
 */
`timescale 1ns/1ps
`default_nettype none
module peer_slot_flags (
   input wire clk_i,
   input wire rst_i,
   input wire ready_i,
   input wire in_reset_i,
   input wire error_i,
   input wire stop_class_i,
   output reg ready_o,
   output reg in_reset_o,
   output reg halt_o,
   output reg ready_chg_o,
   output reg halt_rise_o
);
   wire next_ready;
   wire next_halt;

   // ready only when out of reset and not halted
   assign next_ready = ready_i & ~in_reset_i & ~next_halt;
   // stop-class error halts; continuation errors do not
   // releasing the reset cancels the halt, a live stop error wins
   assign next_halt = (error_i & stop_class_i) | (halt_o & ~(in_reset_o & ~in_reset_i));

   // cleared at reset, then follow the sources
   always @(posedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
         in_reset_o <= 1'b0;
         halt_o <= 1'b0;
         ready_chg_o <= 1'b0;
         halt_rise_o <= 1'b0;
      end else begin
         ready_o <= next_ready;
         in_reset_o <= in_reset_i;
         halt_o <= next_halt;
         ready_chg_o <= next_ready ^ ready_o;
         halt_rise_o <= next_halt & ~halt_o;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/multi_cpu_status_flags.v
/*
 * Multi-CPU status flag bank: fuse fault latch, clock value check,
 * per-peer ready, in-reset and halt fault flags, interrupt status
 * and mask, all behind a classic Wishbone slave.
 * Unmapped offsets read as zero; writes to them are dropped but acked.
 * Assumes status inputs are synchronous to clk_i and that the
 * Wishbone master holds its request until ack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "multi_cpu_status_flags_map.vh"
module multi_cpu_status_flags (
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // status sources
   input wire [`FUSE_MODULES-1:0] fuse_blown_i,
   input wire [`PEERS-1:0] peer_ready_i,
   input wire [`PEERS-1:0] peer_in_reset_i,
   input wire [`PEERS-1:0] peer_error_i,
   input wire [`PEERS-1:0] peer_stop_class_i,
   // flag outputs
   output reg fuse_fault_latch_o,
   output reg clock_value_error_flag_o,
   output reg [`PEERS-1:0] peer_ready_flag_o,
   output reg [`PEERS-1:0] peer_in_reset_flag_o,
   output reg [`PEERS-1:0] peer_halt_fault_flag_o,
   output reg irq_o
);

   // --------------------------------------------------------------
   // functions
   // --------------------------------------------------------------

   // every register is 16 bits wide, so byte lanes 3:2 are ignored
   // merge a write into a 16-bit register under the low byte enables
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] wr;
      input [1:0] sel;
      begin
         merge16[7:0] = sel[0] ? wr[7:0] : old[7:0];
         merge16[15:8] = sel[1] ? wr[15:8] : old[15:8];
      end
   endfunction

   // bits to clear for a write-one-to-clear under the byte enables
   function [15:0] w1c16;
      input [15:0] wr;
      input [1:0] sel;
      begin
         w1c16[7:0] = sel[0] ? wr[7:0] : 8'h00;
         w1c16[15:8] = sel[1] ? wr[15:8] : 8'h00;
      end
   endfunction

   // --------------------------------------------------------------
   // bus decode
   // --------------------------------------------------------------

   wire req;
   wire wr_req;
   wire rd_req;
   // a new access is taken only while ack is low, so each access
   // earns exactly one ack even when the strobe is held
   assign req = cyc_i & stb_i & ~ack_o;
   // writes land at the edge where the master samples ack, the one
   // edge at which it is allowed to consider the access done
   assign wr_req = cyc_i & stb_i & we_i & ack_o;
   // reads are answered from the registered mux one cycle after take
   assign rd_req = req & ~we_i;

   wire hit_ctrl;
   wire hit_w0;
   wire hit_w1;
   wire hit_w2;
   wire hit_w3;
   wire hit_stat;
   wire hit_mask;
   // full 8-bit compares, so no register answers at an alias
   assign hit_ctrl = adr_i == `CTRL_OFS;
   assign hit_w0 = adr_i == `CLK_W0_OFS;
   assign hit_w1 = adr_i == `CLK_W1_OFS;
   assign hit_w2 = adr_i == `CLK_W2_OFS;
   assign hit_w3 = adr_i == `CLK_W3_OFS;
   assign hit_stat = adr_i == `IRQ_STAT_OFS;
   assign hit_mask = adr_i == `IRQ_MASK_OFS;

   // --------------------------------------------------------------
   // stored clock words and check request
   // --------------------------------------------------------------

   reg [`CLK_WORD_W-1:0] clk_word0;
   reg [`CLK_WORD_W-1:0] clk_word1;
   reg [`CLK_WORD_W-1:0] clk_word2;
   reg [`CLK_WORD_W-1:0] clk_word3;
   reg check_req;

   // byte lanes merge, so one byte of a word can be patched alone;
   // the check bit is self-clearing and writing a zero does nothing
   // a check is a one-cycle pulse; words written in the same
   // access cannot race it because they live at other offsets
   always @(posedge clk_i) begin
      if (rst_i) begin
         clk_word0 <= `CLK_WORD_RST;
         clk_word1 <= `CLK_WORD_RST;
         clk_word2 <= `CLK_WORD_RST;
         clk_word3 <= `CLK_WORD_RST;
         check_req <= 1'b0;
      end else begin
         check_req <= wr_req & hit_ctrl & sel_i[0] & dat_i[`CTRL_CHECK_BIT];
         if (wr_req & hit_w0) begin
            clk_word0 <= merge16(clk_word0, dat_i[15:0], sel_i[1:0]);
         end
         if (wr_req & hit_w1) begin
            clk_word1 <= merge16(clk_word1, dat_i[15:0], sel_i[1:0]);
         end
         if (wr_req & hit_w2) begin
            clk_word2 <= merge16(clk_word2, dat_i[15:0], sel_i[1:0]);
         end
         if (wr_req & hit_w3) begin
            clk_word3 <= merge16(clk_word3, dat_i[15:0], sel_i[1:0]);
         end
      end
   end

   // --------------------------------------------------------------
   // clock value checker
   // --------------------------------------------------------------

   // verdict of the checker and its one-cycle valid strobe
   wire chk_error;
   wire chk_done;

   // the verdict lands one cycle after the request pulse
   // validate the four words on request
   clock_value_checker u_checker (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .check_i(check_req),
      .word0_i(clk_word0),
      .word1_i(clk_word1),
      .word2_i(clk_word2),
      .word3_i(clk_word3),
      .error_o(chk_error),
      .done_o(chk_done)
   );

   // --------------------------------------------------------------
   // peer slots
   // --------------------------------------------------------------

   // per-slot flags and the one-cycle event pulses of each slot
   wire [`PEERS-1:0] slot_ready;
   wire [`PEERS-1:0] slot_in_reset;
   wire [`PEERS-1:0] slot_halt;
   wire [`PEERS-1:0] slot_ready_chg;
   wire [`PEERS-1:0] slot_halt_rise;

   // a halt is held through the peer's reset hold and dropped at the
   // release edge, so software sees the stop until the peer restarts
   // one flag set per slot, same logic for all four
   genvar g;
   generate
      for (g = 0; g < `PEERS; g = g + 1) begin : slot
         peer_slot_flags u_slot (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ready_i(peer_ready_i[g]),
            .in_reset_i(peer_in_reset_i[g]),
            .error_i(peer_error_i[g]),
            .stop_class_i(peer_stop_class_i[g]),
            .ready_o(slot_ready[g]),
            .in_reset_o(slot_in_reset[g]),
            .halt_o(slot_halt[g]),
            .ready_chg_o(slot_ready_chg[g]),
            .halt_rise_o(slot_halt_rise[g])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // fuse and clock error flags
   // --------------------------------------------------------------

   // the fuse latch ignores software; only rst_i clears it, so a
   // fuse that blew and recovered between two reads is never missed
   wire any_fuse;
   wire next_fuse;
   wire next_clkerr;
   // any module with a blown fuse
   assign any_fuse = |fuse_blown_i;
   assign next_fuse = fuse_fault_latch_o | any_fuse;
   // the error flag keeps its last verdict between requests
   // set on bad value, cleared on good value
   assign next_clkerr = chk_done ? chk_error : clock_value_error_flag_o;

   always @(posedge clk_i) begin
      if (rst_i) begin
         fuse_fault_latch_o <= 1'b0;
         clock_value_error_flag_o <= 1'b0;
         peer_ready_flag_o <= {`PEERS{1'b0}};
         peer_in_reset_flag_o <= {`PEERS{1'b0}};
         peer_halt_fault_flag_o <= {`PEERS{1'b0}};
      end else begin
         fuse_fault_latch_o <= next_fuse;
         clock_value_error_flag_o <= next_clkerr;
         // peer flags pass one more flop so each pin comes from this
         // module's own register, at the cost of one cycle of latency
         // ready flags exported for software interlock
         peer_ready_flag_o <= slot_ready;
         peer_in_reset_flag_o <= slot_in_reset;
         peer_halt_fault_flag_o <= slot_halt;
      end
   end

   // --------------------------------------------------------------
   // flag word
   // --------------------------------------------------------------

   reg [`FLAG_W-1:0] flags;
   // bits 3:2 are spare and read as zero
   // gathered from the registered outputs so software and pins agree
   always @* begin
      flags = `FLAGS_RST;
      flags[`FUSE_BIT] = fuse_fault_latch_o;
      flags[`CLKERR_BIT] = clock_value_error_flag_o;
      flags[`READY_LSB +: `PEERS] = peer_ready_flag_o;
      flags[`INRST_LSB +: `PEERS] = peer_in_reset_flag_o;
      flags[`HALT_LSB +: `PEERS] = peer_halt_fault_flag_o;
   end

   // --------------------------------------------------------------
   // interrupt status and mask
   // --------------------------------------------------------------

   // sticky status, its mask, and this cycle's events and clears
   reg [`FLAG_W-1:0] irq_stat;
   reg [`FLAG_W-1:0] irq_mask;
   reg [`FLAG_W-1:0] events;
   wire [`FLAG_W-1:0] clr;
   wire [`FLAG_W-1:0] next_irq_stat;

   // events: fuse latches, bad clock value, ready change,
   // reset entry, halt onset; each is a one-cycle pulse
   always @* begin
      events = `FLAGS_RST;
      events[`FUSE_BIT] = next_fuse & ~fuse_fault_latch_o;
      events[`CLKERR_BIT] = chk_done & chk_error;
      events[`READY_LSB +: `PEERS] = slot_ready_chg;
      events[`INRST_LSB +: `PEERS] = slot_in_reset & ~peer_in_reset_flag_o;
      events[`HALT_LSB +: `PEERS] = slot_halt_rise;
   end

   // software clears a status bit by writing a one to it
   assign clr = (wr_req & hit_stat) ? w1c16(dat_i[15:0], sel_i[1:0]) : `FLAGS_RST;
   // a new event wins over a clear in the same cycle
   assign next_irq_stat = (irq_stat & ~clr) | events;

   // the mask gates only the pin, never the status bits themselves
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= `FLAGS_RST;
         irq_mask <= `IRQ_MASK_RST;
         irq_o <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_req & hit_mask) begin
            irq_mask <= merge16(irq_mask, dat_i[15:0], sel_i[1:0]);
         end
         // one cycle behind the status so the pin comes from a flop
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // --------------------------------------------------------------
   // read mux and ack
   // --------------------------------------------------------------

   reg [15:0] rd_val;
   // decodes the offsets of the hit wires above plus the flag word offset
   // unmapped offsets and control read as zero
   always @* begin
      case (adr_i)
         `FLAGS_OFS: begin
            rd_val = flags;
         end
         `CTRL_OFS: begin
            rd_val = 16'h0000;
         end
         `CLK_W0_OFS: begin
            rd_val = clk_word0;
         end
         `CLK_W1_OFS: begin
            rd_val = clk_word1;
         end
         `CLK_W2_OFS: begin
            rd_val = clk_word2;
         end
         `CLK_W3_OFS: begin
            rd_val = clk_word3;
         end
         `IRQ_STAT_OFS: begin
            rd_val = irq_stat;
         end
         `IRQ_MASK_OFS: begin
            rd_val = irq_mask;
         end
         default: begin
            rd_val = 16'h0000;
         end
      endcase
   end

   // read data is zero outside the ack cycle, so a master that samples
   // at the wrong edge picks up nothing stale
   // every access, mapped or not, is acked one cycle after it starts
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (rd_req) begin
            dat_o <= {16'h0000, rd_val};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

// >>> verif/peer_cpu_model.sv
/*
 * Behavioural model of the four peer CPUs on the shared bus.
 * Assumes the bench picks one 2-bit mode per slot; levels change at a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module peer_cpu_model (
   input wire logic clk_i,
   input wire logic [7:0] mode_i,
   output var logic [3:0] ready_o = 4'h0,
   output var logic [3:0] in_reset_o = 4'h0,
   output var logic [3:0] error_o = 4'h0,
   output var logic [3:0] stop_o = 4'h0
);
   // ----------------------------------------
   // slot levels
   // ----------------------------------------
   // modes: 0 run, 1 held in reset, 2 continuation error, 3 stop error
   always @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         ready_o[k] <= ~mode_i[2*k];
         // reset mode drops the error: the cause is gone before reset
         in_reset_o[k] <= mode_i[2*k +: 2] == 2'h1;
         error_o[k] <= mode_i[2*k+1];
         stop_o[k] <= mode_i[2*k +: 2] == 2'h3;
      end
   end
endmodule
`default_nettype wire

// >>> verif/multi_cpu_status_flags_sva.sv
/*
 * Port checker for the status flag bank.
 * Assumes it is bound to the top module; one clock, sync reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mcsf_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [31:0] dat_o,
   input wire logic [7:0] fuse_blown_i,
   input wire logic [3:0] peer_ready_i,
   input wire logic [3:0] peer_in_reset_i,
   input wire logic [3:0] peer_error_i,
   input wire logic [3:0] peer_stop_class_i,
   input wire logic fuse_fault_latch_o,
   input wire logic clock_value_error_flag_o,
   input wire logic [3:0] peer_ready_flag_o,
   input wire logic [3:0] peer_in_reset_flag_o,
   input wire logic [3:0] peer_halt_fault_flag_o,
   input wire logic irq_o
);
   // ----------------------------------------
   // settle counter
   // ----------------------------------------
   // history checks wait three edges so $past never sees reset
   logic [1:0] up;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up <= 2'h0;
      end else if (up != 2'h3) begin
         up <= up + 2'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   ack_follow_a: assert property (req_s |=> ack_o) else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("dat idle");
   fuse_set_a: assert property (|fuse_blown_i |=> fuse_fault_latch_o)
      else $error("fuse latch missed");
   fuse_hold_a: assert property (fuse_fault_latch_o |=> fuse_fault_latch_o)
      else $error("fuse latch lost");
   flags_clear_a: assert property (disable iff (1'b0) rst_i |=> !irq_o &&
      !fuse_fault_latch_o && !clock_value_error_flag_o && peer_ready_flag_o == 4'h0
      && peer_in_reset_flag_o == 4'h0 && peer_halt_fault_flag_o == 4'h0)
      else $error("flags not clear");
   inrst_track_a: assert property (up == 2'h3 |->
      peer_in_reset_flag_o == $past(peer_in_reset_i, 2)) else $error("in-reset flag");
   halt_set_a: assert property (up == 2'h3 |->
      (peer_halt_fault_flag_o & $past(peer_error_i & peer_stop_class_i, 2))
      == $past(peer_error_i & peer_stop_class_i, 2)) else $error("halt missed");
   halt_cause_a: assert property (up == 2'h3 |->
      (peer_halt_fault_flag_o & ~$past(peer_halt_fault_flag_o)
      & ~$past(peer_error_i & peer_stop_class_i, 2)) == 4'h0) else $error("halt cause");
   ready_cause_a: assert property (up == 2'h3 |->
      (peer_ready_flag_o & ~$past(peer_ready_i & ~peer_in_reset_i, 2)) == 4'h0)
      else $error("ready cause");
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the status flag bank.
 * Assumes the peer model and checker compile first; 50 ns clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "multi_cpu_status_flags_map.vh"
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [7:0] fuse_blown_i = 8'h00;
   logic [7:0] mode = 8'h00;
   wire logic [31:0] dat_o;
   wire logic ack_o;
   wire logic fuse_fault_latch_o;
   wire logic clock_value_error_flag_o;
   wire logic irq_o;
   wire logic [3:0] peer_ready_i;
   wire logic [3:0] peer_in_reset_i;
   wire logic [3:0] peer_error_i;
   wire logic [3:0] peer_stop_class_i;
   wire logic [3:0] peer_ready_flag_o;
   wire logic [3:0] peer_in_reset_flag_o;
   wire logic [3:0] peer_halt_fault_flag_o;
   logic [31:0] exp_q[$];
   logic [31:0] d;
   logic [63:0] cw [4] = '{64'h2024_0612_1010_0303, 64'h2024_1313_1010_0303,
      64'h20A4_0612_1010_0303, 64'h9999_1212_2323_0606};
   logic [3:0] ce = 4'b0110;
   int seed = 16;
   int num_errors = 0;
   int n_tests = 0;
   always #25 clk_i = ~clk_i;
   multi_cpu_status_flags dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
      .dat_i, .dat_o, .ack_o, .fuse_blown_i, .peer_ready_i, .peer_in_reset_i,
      .peer_error_i, .peer_stop_class_i, .fuse_fault_latch_o, .clock_value_error_flag_o,
      .peer_ready_flag_o, .peer_in_reset_flag_o, .peer_halt_fault_flag_o, .irq_o);
   peer_cpu_model peer_u (.clk_i, .mode_i(mode), .ready_o(peer_ready_i),
      .in_reset_o(peer_in_reset_i), .error_o(peer_error_i), .stop_o(peer_stop_class_i));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hold the request until ack is sampled, then idle one cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= v;
      sel_i <= 4'h3;
      @(posedge clk_i);
      // the slave sets the pace; only the watchdog ends a lost answer
      while (ack_o !== 1'b1) begin
         @(posedge clk_i);
         n++;
      end
      // the registered slave answers one edge after it takes a request
      check("ack delay", n, 32'h0000_0001);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   // read data is judged at the ack edge against the oldest note
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         if (exp_q.size() > 0) begin
            check("rdata", dat_o, exp_q.pop_front());
         end else begin
            check("spare ack", 32'h0000_0001, 32'h0000_0000);
         end
      end
   end
   initial begin
      repeat (4000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("reset", {fuse_fault_latch_o, clock_value_error_flag_o, peer_ready_flag_o,
         peer_in_reset_flag_o, peer_halt_fault_flag_o, irq_o}, 32'h0000_0000);
      rd(`IRQ_MASK_OFS, 32'h0000_0000);
      rd(`CLK_W0_OFS, 32'h0000_0000);
      // software waits on ready before bus transfers
      for (int i = 0; i < 20 && peer_ready_flag_o !== 4'hF; i++) @(posedge clk_i);
      check("ready", peer_ready_flag_o, 32'h0000_000F);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         wb(1'b1, `CLK_W0_OFS + 8'(4 * i), d);
         rd(`CLK_W0_OFS + 8'(4 * i), {16'h0000, d[15:0]});
      end
      rd(8'h20, 32'h0000_0000);
      rd(`CTRL_OFS, 32'h0000_0000);
      wb(1'b1, `FLAGS_OFS, 32'h0000_FFFF);
      rd(`FLAGS_OFS, 32'h0000_00F0);
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            wb(1'b1, `CLK_W0_OFS + 8'(4 * j), {16'h0000, cw[i][63 - 16 * j -: 16]});
         end
         wb(1'b1, `CTRL_OFS, 32'h0000_0001);
         repeat (3) @(posedge clk_i);
         check("clkerr", clock_value_error_flag_o, {31'h0, ce[i]});
      end
      wb(1'b1, `IRQ_MASK_OFS, 32'h0000_0000);
      wb(1'b1, `IRQ_STAT_OFS, 32'h0000_FFFF);
      fuse_blown_i <= 8'h80;
      @(posedge clk_i);
      fuse_blown_i <= 8'h00;
      repeat (3) @(posedge clk_i);
      check("fuse", fuse_fault_latch_o, 32'h0000_0001);
      check("irq masked", irq_o, 32'h0000_0000);
      wb(1'b1, `IRQ_MASK_OFS, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      check("irq on", irq_o, 32'h0000_0001);
      wb(1'b1, `IRQ_STAT_OFS, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      check("irq off", irq_o, 32'h0000_0000);
      check("fuse kept", fuse_fault_latch_o, 32'h0000_0001);
      mode <= 8'h39;
      repeat (5) @(posedge clk_i);
      check("ready", peer_ready_flag_o, 32'h0000_000A);
      check("inrst", peer_in_reset_flag_o, 32'h0000_0001);
      check("halt", peer_halt_fault_flag_o, 32'h0000_0004);
      rd(`FLAGS_OFS, 32'h0000_41A1);
      // ready changes of slots 0 and 2, reset entry of 0, halt onset of 2
      rd(`IRQ_STAT_OFS, 32'h0000_4150);
      mode <= 8'h09;
      repeat (5) @(posedge clk_i);
      check("halt held", peer_halt_fault_flag_o, 32'h0000_0004);
      // stop error cleared by resetting the peer
      mode <= 8'h19;
      repeat (5) @(posedge clk_i);
      check("inrst", peer_in_reset_flag_o, 32'h0000_0005);
      mode <= 8'h00;
      repeat (5) @(posedge clk_i);
      check("halt gone", peer_halt_fault_flag_o, 32'h0000_0000);
      check("ready back", peer_ready_flag_o, 32'h0000_000F);
      close_out();
   end
endmodule
bind multi_cpu_status_flags mcsf_sva chk_u (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .dat_o, .fuse_blown_i, .peer_ready_i, .peer_in_reset_i, .peer_error_i,
   .peer_stop_class_i, .fuse_fault_latch_o, .clock_value_error_flag_o,
   .peer_ready_flag_o, .peer_in_reset_flag_o, .peer_halt_fault_flag_o, .irq_o);
`default_nettype wire
